// ==== rtl/sam_defines.svh ====
`ifndef SAM_DEFINES_SVH
`define SAM_DEFINES_SVH

// byte address width: 2**27 bytes is the 128 MB ceiling
`define SAM_ADDR_W        27
// extra memory cycles on a burst's first access when not synchronous
`define SAM_ASYNC_EXTRA   3'h4
`define SAM_SYNC_EXTRA    3'h0
// memory clock divider after reset: enable every second cycle
`define SAM_DIV_RST       4'h1
// external chip-select banks per density
`define SAM_EXT_BANKS_16M 3'h4
`define SAM_EXT_BANKS_64M 3'h2
// strap capture happens once the synchroniser holds the pin level
`define SAM_STRAP_CAP_AT  2'h2
`define SAM_STRAP_DONE    2'h3

`endif

// ==== rtl/sam_pkg.sv ====
package sam_pkg;

	// address mapping selected from density and internal bank count
	typedef enum logic [1:0] {
		SAM_MAP_16M2 = 2'h0,
		SAM_MAP_64M2 = 2'h1,
		SAM_MAP_64M4 = 2'h2
	} sam_map_e;

	// supported clock configurations
	typedef enum logic [1:0] {
		SAM_CLK_S66  = 2'h0,
		SAM_CLK_A100 = 2'h1,
		SAM_CLK_S100 = 2'h2
	} sam_clkcfg_e;

	// memory clock divider reprogramming
	typedef enum logic [1:0] {
		SAM_DIV_RUN  = 2'b01,
		SAM_DIV_PEND = 2'b10
	} sam_div_st_e;

endpackage : sam_pkg

// ==== rtl/sam_bank_decode.sv ====
`timescale 1ns/1ps
`include "sam_defines.svh"

module sam_bank_decode (
	// memory-side byte address and bank geometry
	input  wire logic [26:0] mem_addr,
	input  wire logic [4:0]  bank_shift,
	input  wire logic        four_ext,
	input  wire logic [3:0]  populated,
	// decoded external bank
	output logic      [1:0]  bank_idx,
	output logic             hit
);

	logic [26:0] idx_full;
	logic [2:0]  limit;

	always_comb begin
		idx_full = mem_addr >> bank_shift;
		// RULE_02 four banks at 16 Mbit
		// RULE_03 two banks otherwise
		limit    = four_ext ? `SAM_EXT_BANKS_16M : `SAM_EXT_BANKS_64M;
		bank_idx = idx_full[1:0];
		// RULE_04 bank 0 always present
		hit      = (idx_full < {24'h0, limit})
			&& (populated[bank_idx] || (bank_idx == 2'h0));
	end

endmodule : sam_bank_decode

// ==== rtl/sam_top.sv ====
// What this block does
// RULE_01 - At most 128 MB is addressed and every bank is 64 bits wide.
// RULE_02 - With 16 Mbit parts four chip selects give up to four banks.
// RULE_03 - With 64/128 Mbit parts only two banks exist as two selects move.
// RULE_04 - Graphics sits at the bottom of bank 0 and host memory above it.
// RULE_05 - 16 Mbit row phase: bank select 0 is A11, lines 10..0 A22..A12.
// RULE_06 - 16 Mbit column phase: line 10 low, 9..8 A24..A23, 7..0 A10..A3.
// RULE_07 - 64/128 Mbit row phase per bank count as two or four banks.
// RULE_08 - 64/128 Mbit column phase: lines 10 up low, 9..8 A26..A25.
// RULE_09 - 64/128 Mbit: select two carries line 11, three line 12 or BS1.
// RULE_10 - Sync strap ties clocks and saves 4 memory cycles per burst.
// RULE_11 - Only three clock configurations are supported.
// RULE_12 - In async mode the memory clock rate may change while running.
// RULE_13 - Attached memory should run at a CAS latency of two.
// RULE_14 - Density and internal bank count select the address mapping.
`timescale 1ns/1ps
`include "sam_defines.svh"

module sam_top (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 srst,
	// configuration
	input  wire logic                 cfg_density_64,
	input  wire logic                 cfg_four_banks,
	input  wire sam_pkg::sam_clkcfg_e cfg_clk_mode,
	input  wire logic [26:0]          cfg_gfx_size,
	input  wire logic [4:0]           cfg_bank_shift,
	input  wire logic [3:0]           cfg_bank_populated,
	input  wire logic                 sync_strap_pin,
	// memory clock programming
	input  wire logic [3:0]           mclk_div,
	input  wire logic                 mclk_div_load,
	// address request
	input  wire logic                 req_valid,
	input  wire logic                 req_col,
	input  wire logic                 req_gfx,
	input  wire logic [26:0]          req_addr,
	// memory pins
	output logic      [10:0]          mem_addr_lines,
	output logic                      bank_select_zero,
	output logic      [1:0]           chip_select_n,
	output logic                      chip_select_two_n,
	output logic                      chip_select_three_n,
	// status
	output logic                      addr_valid,
	output logic                      addr_range_err,
	output logic      [2:0]           first_access_extra,
	output logic                      mclk_en,
	output logic                      div_reject,
	output logic                      sync_mode,
	output logic                      core_ratio_two,
	output logic                      cfg_error
);

	// returns {bs0, bs1, lines[12:0]}
	function automatic logic [14:0] sam_map_addr(
		input sam_pkg::sam_map_e m,
		input logic              col,
		input logic [26:0]       a
	);
		logic [14:0] r;
		r = 15'h0;
		case (m)
			sam_pkg::SAM_MAP_16M2: begin
				// RULE_05 16M row map
				// RULE_06 16M column map
				r[14]   = a[11];
				r[10:0] = col ? {1'b0, a[24:23], a[10:3]} : a[22:12];
			end
			sam_pkg::SAM_MAP_64M4: begin
				// RULE_07 four-bank row map
				// RULE_08 column repeats selects
				r[14]   = a[11];
				r[13]   = a[12];
				r[11:0] = col ? {2'h0, a[26:25], a[10:3]} : a[24:13];
			end
			default: begin
				// RULE_07 two-bank row map
				// RULE_08 upper lines low
				r[14]   = a[11];
				r[12:0] = col ? {3'h0, a[26:25], a[10:3]} : a[24:12];
			end
		endcase
		return r;
	endfunction : sam_map_addr

	// strap synchroniser and one-time capture
	logic       strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;
	logic [1:0] cap_cnt_q, cap_cnt_d;
	logic       sync_q, sync_d, ratio_q, ratio_d, cerr_q, cerr_d;
	logic [2:0] extra_q, extra_d;
	sam_pkg::sam_map_e map;

	always_comb begin
		strap_s1_d = sync_strap_pin;
		strap_s2_d = strap_s1_q;
		cap_cnt_d  = cap_cnt_q;
		sync_d     = sync_q;
		// straps are sampled once so the clock relation cannot flip later
		if (cap_cnt_q != `SAM_STRAP_DONE) begin
			cap_cnt_d = cap_cnt_q + 2'h1;
		end
		if (cap_cnt_q == `SAM_STRAP_CAP_AT) begin
			sync_d = strap_s2_q;
		end
		// RULE_10 async adds first-access cycles
		// follows the captured strap in the same cycle as sync_mode
		extra_d = sync_d ? `SAM_SYNC_EXTRA : `SAM_ASYNC_EXTRA;
		// RULE_14 mapping from density and banks
		if (!cfg_density_64) begin
			map = sam_pkg::SAM_MAP_16M2;
		end else if (cfg_four_banks) begin
			map = sam_pkg::SAM_MAP_64M4;
		end else begin
			map = sam_pkg::SAM_MAP_64M2;
		end
		// RULE_11 only listed clock setups
		ratio_d = (cfg_clk_mode != sam_pkg::SAM_CLK_S100);
		cerr_d  = (!cfg_density_64 && cfg_four_banks)
			|| (cfg_clk_mode == 2'h3)
			|| ((cap_cnt_q == `SAM_STRAP_DONE)
				&& ((cfg_clk_mode == sam_pkg::SAM_CLK_A100) == sync_q));
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			cap_cnt_q  <= 2'h0;
			sync_q     <= 1'b0;
			extra_q    <= `SAM_ASYNC_EXTRA;
			ratio_q    <= 1'b0;
			cerr_q     <= 1'b0;
		end else begin
			strap_s1_q <= strap_s1_d;
			strap_s2_q <= strap_s2_d;
			cap_cnt_q  <= cap_cnt_d;
			sync_q     <= sync_d;
			extra_q    <= extra_d;
			ratio_q    <= ratio_d;
			cerr_q     <= cerr_d;
		end
	end

	// address path
	logic [27:0] phys_sum;
	logic [1:0]  bank_idx;
	logic        bank_hit, err, gfx_over;
	logic [14:0] mapped;
	logic [10:0] ma_q, ma_d;
	logic        ba0_q, ba0_d, val_q, val_d, rerr_q, rerr_d;
	logic [1:0]  cs01_q, cs01_d;
	logic        cs2_q, cs2_d, cs3_q, cs3_d;

	sam_bank_decode u_decode (
		.mem_addr  (phys_sum[26:0]),
		.bank_shift(cfg_bank_shift),
		.four_ext  (map == sam_pkg::SAM_MAP_16M2),
		.populated (cfg_bank_populated),
		.bank_idx  (bank_idx),
		.hit       (bank_hit)
	);

	always_comb begin
		// RULE_04 host space starts above graphics
		phys_sum = {1'b0, req_addr} + (req_gfx ? 28'h0 : {1'b0, cfg_gfx_size});
		gfx_over = req_gfx && (req_addr >= cfg_gfx_size);
		// RULE_01 nothing beyond 128 MB
		err      = phys_sum[27] || gfx_over || !bank_hit;
		mapped   = sam_map_addr(map, req_col, phys_sum[26:0]);
		ma_d     = ma_q;
		ba0_d    = ba0_q;
		val_d    = req_valid;
		rerr_d   = req_valid && err;
		cs01_d   = 2'b11;
		cs2_d    = (map == sam_pkg::SAM_MAP_16M2) ? 1'b1 : cs2_q;
		cs3_d    = (map == sam_pkg::SAM_MAP_16M2) ? 1'b1 : cs3_q;
		if (req_valid) begin
			ma_d  = mapped[10:0];
			ba0_d = mapped[14];
			if (map == sam_pkg::SAM_MAP_16M2) begin
				// RULE_02 one of four selects
				{cs3_d, cs2_d, cs01_d} = err ? 4'hf : ~(4'h1 << bank_idx);
			end else begin
				// RULE_03 only selects zero and one
				cs01_d = err ? 2'b11 : ~(2'b01 << bank_idx[0]);
				// RULE_09 selects two/three carry address
				cs2_d  = mapped[11];
				cs3_d  = (map == sam_pkg::SAM_MAP_64M4) ? mapped[13] : mapped[12];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ma_q   <= 11'h0;
			ba0_q  <= 1'b0;
			val_q  <= 1'b0;
			rerr_q <= 1'b0;
			cs01_q <= 2'b11;
			cs2_q  <= 1'b1;
			cs3_q  <= 1'b1;
		end else begin
			ma_q   <= ma_d;
			ba0_q  <= ba0_d;
			val_q  <= val_d;
			rerr_q <= rerr_d;
			cs01_q <= cs01_d;
			cs2_q  <= cs2_d;
			cs3_q  <= cs3_d;
		end
	end

	// memory clock enable divider
	sam_pkg::sam_div_st_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d, div_q, div_d, pend_q, pend_d;
	logic       en_q, en_d, rej_q, rej_d;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		div_d  = div_q;
		pend_d = pend_q;
		en_d   = 1'b0;
		rej_d  = 1'b0;
		if (sync_q) begin
			// RULE_10 memory clock follows host clock
			en_d  = 1'b1;
			cnt_d = 4'h0;
			st_d  = sam_pkg::SAM_DIV_RUN;
			// RULE_12 no reprogramming when synchronous
			rej_d = mclk_div_load;
		end else begin
			// RULE_12 new rate taken at a period edge, so no runt period
			if (mclk_div_load) begin
				pend_d = mclk_div;
				st_d   = sam_pkg::SAM_DIV_PEND;
			end
			if (cnt_q == 4'h0) begin
				en_d = 1'b1;
				case (st_q)
					sam_pkg::SAM_DIV_PEND: begin
						div_d = pend_q;
						cnt_d = pend_q;
						if (!mclk_div_load) begin
							st_d = sam_pkg::SAM_DIV_RUN;
						end
					end
					default: begin
						cnt_d = div_q;
					end
				endcase
			end else begin
				cnt_d = cnt_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q   <= sam_pkg::SAM_DIV_RUN;
			cnt_q  <= 4'h0;
			div_q  <= `SAM_DIV_RST;
			pend_q <= `SAM_DIV_RST;
			en_q   <= 1'b0;
			rej_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			div_q  <= div_d;
			pend_q <= pend_d;
			en_q   <= en_d;
			rej_q  <= rej_d;
		end
	end

	assign mem_addr_lines      = ma_q;
	assign bank_select_zero    = ba0_q;
	assign chip_select_n       = cs01_q;
	assign chip_select_two_n   = cs2_q;
	assign chip_select_three_n = cs3_q;
	assign addr_valid          = val_q;
	assign addr_range_err      = rerr_q;
	assign first_access_extra  = extra_q;
	assign mclk_en             = en_q;
	assign div_reject          = rej_q;
	assign sync_mode           = sync_q;
	assign core_ratio_two      = ratio_q;
	assign cfg_error           = cerr_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_two_gaps;
		!en_q ##1 !en_q ##1 en_q;
	endsequence

	a_extra_by_mode: assert property ( // RULE_10
		extra_q == (sync_q ? 3'h0 : 3'h4))
		else $error("first access extra wrong for mode");
	a_sync_every_cycle: assert property ( // RULE_10
		sync_q |=> en_q)
		else $error("memory enable missing in sync mode");
	a_row16_lines: assert property ( // RULE_05
		req_valid && !req_col && (map == sam_pkg::SAM_MAP_16M2)
		|=> (ma_q == $past(phys_sum[22:12])) && (ba0_q == $past(phys_sum[11])))
		else $error("16M row lines wrong");
	a_col16_lines: assert property ( // RULE_06
		req_valid && req_col && (map == sam_pkg::SAM_MAP_16M2)
		|=> ma_q == {1'b0, $past(phys_sum[24:23]), $past(phys_sum[10:3])})
		else $error("16M column lines wrong");
	a_col64_upper: assert property ( // RULE_08
		req_valid && req_col && (map != sam_pkg::SAM_MAP_16M2)
		|=> !ma_q[10] && (ma_q[9:8] == $past(phys_sum[26:25])) && !cs2_q)
		else $error("64M column upper lines not low");
	a_row64_pins: assert property ( // RULE_09
		req_valid && !req_col && (map == sam_pkg::SAM_MAP_64M2)
		|=> (cs2_q == $past(phys_sum[23])) && (cs3_q == $past(phys_sum[24])))
		else $error("select pins not carrying lines 11/12");
	a_four_bank_sel: assert property ( // RULE_07
		req_valid && !req_col && (map == sam_pkg::SAM_MAP_64M4)
		|=> (cs3_q == $past(phys_sum[12])) && (ma_q == $past(phys_sum[23:13])))
		else $error("four-bank row map wrong");
	a_err_no_select: assert property ( // RULE_01
		rerr_q |-> (cs01_q == 2'b11))
		else $error("select asserted on range error");
	a_two_ext_banks: assert property ( // RULE_03
		req_valid && (map != sam_pkg::SAM_MAP_16M2) && !phys_sum[27]
		&& ((phys_sum[26:0] >> cfg_bank_shift) > 27'h1) |=> rerr_q)
		else $error("third bank accepted with 64M parts");
	a_div_period: assert property ( // RULE_12
		en_q && !sync_q && (cnt_q == 4'h2) |=> s_two_gaps)
		else $error("memory clock period wrong");
	a_div_apply: assert property ( // RULE_12
		!sync_q && (st_q == sam_pkg::SAM_DIV_PEND) && (cnt_q == 4'h0)
		|=> (div_q == $past(pend_q)) && en_q)
		else $error("pending divider not applied at edge");
	a_div_refused: assert property ( // RULE_12
		mclk_div_load && sync_q |=> rej_q && $stable(div_q))
		else $error("divider change not refused in sync mode");

endmodule : sam_top

// ==== testbench/sam_sdram_model.sv ====
`timescale 1ns/1ps

module sam_sdram_model #(
	parameter int CAS_LAT = 2,
	parameter int DATA_W  = 64
) (
	// clock
	input  wire logic        clock,
	// memory pins
	input  wire logic [10:0] mem_addr_lines,
	input  wire logic        bank_select_zero,
	input  wire logic [1:0]  chip_select_n,
	input  wire logic        chip_select_two_n,
	input  wire logic        chip_select_three_n,
	input  wire logic        wide_parts,
	// what the selected bank latched
	output logic             seen_q,
	output logic      [1:0]  seen_bank_q,
	output logic      [12:0] seen_addr_q
);
	logic sel_hi;
	// in wide mode selects two and three carry address levels, not selects
	assign sel_hi = !wide_parts && !(chip_select_two_n && chip_select_three_n);

	always_ff @(posedge clock) begin
		seen_q <= !chip_select_n[0] || !chip_select_n[1] || sel_hi;
		if (!chip_select_n[0] || !chip_select_n[1] || sel_hi) begin
			seen_bank_q <= !chip_select_n[0] ? 2'h0 : !chip_select_n[1] ? 2'h1
				: !chip_select_two_n ? 2'h2 : 2'h3;
			seen_addr_q <= wide_parts ?
				{chip_select_three_n, chip_select_two_n, mem_addr_lines}
				: {2'h0, mem_addr_lines};
		end
	end
endmodule : sam_sdram_model

// ==== testbench/test_sam_top.sv ====
`timescale 1ns/1ps

module test_sam_top;
	logic        clock, srst, cfg_density_64, cfg_four_banks, sync_strap_pin;
	logic        mclk_div_load, req_valid, req_col, req_gfx;
	logic [26:0] cfg_gfx_size, req_addr;
	logic [4:0]  cfg_bank_shift;
	logic [3:0]  cfg_bank_populated, mclk_div;
	logic [10:0] mem_addr_lines;
	logic        bank_select_zero, chip_select_two_n, chip_select_three_n;
	logic        addr_valid, addr_range_err, mclk_en, div_reject, sync_mode;
	logic        core_ratio_two, cfg_error, seen_q;
	logic [1:0]  chip_select_n, seen_bank_q;
	logic [2:0]  first_access_extra;
	logic [12:0] seen_addr_q;
	int          mismatches, compares, n;
	sam_pkg::sam_clkcfg_e cfg_clk_mode;

	sam_top DUT (.clock, .srst, .cfg_density_64, .cfg_four_banks,
		.cfg_clk_mode, .cfg_gfx_size, .cfg_bank_shift, .cfg_bank_populated,
		.sync_strap_pin, .mclk_div, .mclk_div_load, .req_valid, .req_col,
		.req_gfx, .req_addr, .mem_addr_lines, .bank_select_zero,
		.chip_select_n, .chip_select_two_n, .chip_select_three_n, .addr_valid,
		.addr_range_err, .first_access_extra, .mclk_en, .div_reject,
		.sync_mode, .core_ratio_two, .cfg_error);

	sam_sdram_model mdl (.clock, .mem_addr_lines, .bank_select_zero,
		.chip_select_n, .chip_select_two_n, .chip_select_three_n,
		.wide_parts(cfg_density_64), .seen_q, .seen_bank_q, .seen_addr_q);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [26:0] s, e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick

	task automatic reset;
		srst = 1'b1;
		tick(5);
		srst = 1'b0;
		tick(5);
	endtask : reset

	// pin image {12,11,10..0} expected for a physical address
	function automatic logic [12:0] pins(input logic [26:0] a, input logic c);
		// four internal banks: bank select one repeats A12 in the column
		if (c)
			return {cfg_density_64 && cfg_four_banks && a[12], 2'h0,
				cfg_density_64 ? a[26:25] : a[24:23], a[10:3]};
		if (!cfg_density_64)
			return {2'h0, a[22:12]};
		if (!cfg_four_banks)
			return a[24:12];
		return {a[12], a[24:13]};
	endfunction : pins

	task automatic req(input logic c, g, input logic [26:0] a, input logic e);
		logic [26:0] p;
		p = g ? a : a + cfg_gfx_size;
		req_col   = c;
		req_gfx   = g;
		req_addr  = a;
		req_valid = 1'b1;
		tick(1);
		req_valid = 1'b0;
		chk("valid", addr_valid, 1'b1);
		chk("range", addr_range_err, e);
		tick(1);
		chk("sel", seen_q, !e);
		chk("idle", chip_select_n, 2'h3);
		if (!e) begin
			chk("bank", seen_bank_q, p >> cfg_bank_shift);
			chk("bs0", bank_select_zero, p[11]);
			chk("pins", seen_addr_q, pins(p, c));
		end
	endtask : req

	// measures cycles between two memory clock enables
	task automatic gap(output int g);
		g = 0;
		while (mclk_en !== 1'b1 && g < 40) begin
			tick(1);
			g++;
		end
		g = 0;
		do begin
			tick(1);
			g++;
		end while (mclk_en !== 1'b1 && g < 40);
	endtask : gap

	initial begin
		#40000;
		mismatches++;
		close_out();
	end

	initial begin
		{srst, cfg_density_64, cfg_four_banks, sync_strap_pin} = 4'h0;
		{mclk_div_load, req_valid, req_col, req_gfx} = 4'h0;
		{mismatches, compares} = 0;
		mclk_div = 4'h0;
		req_addr = 27'h0;
		cfg_clk_mode = sam_pkg::SAM_CLK_A100;
		cfg_gfx_size = 27'h0100000;
		cfg_bank_shift = 5'h18;
		cfg_bank_populated = 4'hf;
		reset();
		chk("extra", first_access_extra, 3'h4);
		chk("ratio", core_ratio_two, 1'b1);
		chk("cfgerr", cfg_error, 1'b0);
		req(1'b0, 1'b1, 27'h00a5a38, 1'b0);
		req(1'b1, 1'b1, 27'h00a5a38, 1'b0);
		req(1'b0, 1'b0, 27'h2fff000, 1'b0);
		req(1'b1, 1'b0, 27'h1f80008, 1'b0);
		req(1'b0, 1'b1, 27'h0100000, 1'b1);
		req(1'b0, 1'b0, 27'h7f00000, 1'b1);
		cfg_bank_populated = 4'h7;
		req(1'b0, 1'b0, 27'h2fff000, 1'b1);
		cfg_density_64 = 1'b1;
		cfg_bank_shift = 5'h19;
		req(1'b0, 1'b0, 27'h1abcdef, 1'b0);
		req(1'b1, 1'b0, 27'h3abcdef, 1'b0);
		req(1'b0, 1'b0, 27'h4000000, 1'b1);
		cfg_four_banks = 1'b1;
		req(1'b0, 1'b0, 27'h1abdfff, 1'b0);
		req(1'b1, 1'b0, 27'h3abdfff, 1'b0);
		cfg_density_64 = 1'b0;
		tick(2);
		chk("cfgerr", cfg_error, 1'b1);
		cfg_four_banks = 1'b0;
		cfg_clk_mode = sam_pkg::sam_clkcfg_e'(2'h3);
		tick(2);
		chk("cfgerr", cfg_error, 1'b1);
		cfg_clk_mode = sam_pkg::SAM_CLK_A100;
		mclk_div = 4'h2;
		mclk_div_load = 1'b1;
		tick(1);
		mclk_div_load = 1'b0;
		chk("rej", div_reject, 1'b0);
		gap(n);
		gap(n);
		chk("period", n[26:0], 27'h3);
		sync_strap_pin = 1'b1;
		cfg_clk_mode = sam_pkg::SAM_CLK_S66;
		reset();
		sync_strap_pin = 1'b0;
		tick(2);
		chk("sync", sync_mode, 1'b1);
		chk("extra", first_access_extra, 3'h0);
		chk("cfgerr", cfg_error, 1'b0);
		chk("en", mclk_en, 1'b1);
		mclk_div_load = 1'b1;
		tick(1);
		mclk_div_load = 1'b0;
		chk("rej", div_reject, 1'b1);
		cfg_clk_mode = sam_pkg::SAM_CLK_S100;
		tick(2);
		chk("ratio", core_ratio_two, 1'b0);
		close_out();
	end
endmodule : test_sam_top
